// File: design/dma_regs_defs.svh
`ifndef DMA_REGS_DEFS_SVH
`define DMA_REGS_DEFS_SVH

// ****************************************
// Bus map (byte addresses)
// ****************************************
`define WR_PORT_OFS 8'h00
`define RD_PORT_OFS 8'h04
`define STATUS_OFS 8'h08
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ****************************************
// Register file
// ****************************************
`define NUM_WREGS 21
`define NUM_RREGS 7
`define GRP0_START 5'h00
`define GRP1_START 5'h05
`define GRP2_START 5'h07
`define GRP3_START 5'h0A
`define GRP4_START 5'h0D
`define GRP5_START 5'h12
`define GRP6_START 5'h13
`define IDX_G0_BASE 5'h00
`define IDX_A_LO 5'h01
`define IDX_A_HI 5'h02
`define IDX_LEN_LO 5'h03
`define IDX_LEN_HI 5'h04
`define IDX_A_CFG 5'h06
`define IDX_B_CFG 5'h08
`define IDX_B_TIMING 5'h09
`define IDX_G3_BASE 5'h0A
`define IDX_MATCH_MASK 5'h0B
`define IDX_MATCH_VAL 5'h0C
`define IDX_G4_BASE 5'h0D
`define IDX_B_LO 5'h0E
`define IDX_B_HI 5'h0F
`define IDX_PULSE_OFS 5'h10
`define IDX_PULSE_CTL 5'h11
`define IDX_G5_BASE 5'h12
`define IDX_RD_MASK 5'h14
`define RDMASK_RST 8'h7F

// ****************************************
// Field positions and codes
// ****************************************
`define F_CTRL 7
`define F_PTR_LSB 3
`define F_CMD_LSB 4
`define F_MODE_LSB 2
`define F_TWO_CYC 0
`define F_PULSE_EN 0
`define GRP_NONE 3'h7
`define CMD_LOAD 4'h1
`define CMD_ENABLE 4'h2
`define CMD_DISABLE 4'h3
`define CMD_FORCE_RDY 4'h4
`define CMD_RD_RESTART 4'h5
`define OP_BYTE 2'h0
`define OP_BURST 2'h1
`define OP_CONT 2'h2
`define CLS_XFER 2'h0
`define CLS_SEARCH 2'h1
`define CLS_XSEARCH 2'h2
`define CLS_SIM 2'h3
`define AM_DEC 2'h0
`define AM_INC 2'h1
`define ST_ENABLED 0
`define ST_READY 1
`define ST_EOB 4
`define ST_MATCH 5

`endif

// File: design/dma_regs_pkg.sv
package dma_regs_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_REQ,
    ST_READ,
    ST_WRITE,
    ST_EXTRA
  } state_t;

endpackage : dma_regs_pkg

// File: design/dma_registers_and_counters.sv
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`include "dma_regs_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module dma_registers_and_counters #(
  parameter int AXI_ADDR_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic busRequestLine,
  input wire logic busGrantLine,
  input wire logic readyIn,
  output logic [15:0] sysAddr,
  output logic memRd,
  output logic memWr,
  input wire logic [7:0] rdData,
  output logic [7:0] wrData,
  output logic pulseOut
);

  if (AXI_ADDR_W < 8) begin : gBadAddrW
    $error("AXI_ADDR_W must be at least 8");
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [4:0] grpStart(input logic [2:0] g);
    case (g)
      3'h0: grpStart = `GRP0_START;
      3'h1: grpStart = `GRP1_START;
      3'h2: grpStart = `GRP2_START;
      3'h3: grpStart = `GRP3_START;
      3'h4: grpStart = `GRP4_START;
      3'h5: grpStart = `GRP5_START;
      default: grpStart = `GRP6_START;
    endcase
  endfunction : grpStart

  // Pointer bits that name a real secondary register of the group
  function automatic logic [3:0] ptrMask(input logic [2:0] g);
    case (g)
      3'h0: ptrMask = 4'hF;
      3'h1: ptrMask = 4'h1;
      3'h2: ptrMask = 4'h3;
      3'h3: ptrMask = 4'h3;
      3'h4: ptrMask = 4'hF;
      3'h6: ptrMask = 4'h1;
      default: ptrMask = 4'h0;
    endcase
  endfunction : ptrMask

  function automatic logic [1:0] lowBit(input logic [3:0] p);
    if (p[0]) begin
      lowBit = 2'h0;
    end else if (p[1]) begin
      lowBit = 2'h1;
    end else if (p[2]) begin
      lowBit = 2'h2;
    end else begin
      lowBit = 2'h3;
    end
  endfunction : lowBit

  function automatic logic [15:0] stepAddr(input logic [15:0] a, input logic [1:0] m);
    case (m)
      `AM_DEC: stepAddr = a - 16'h0001;
      `AM_INC: stepAddr = a + 16'h0001;
      default: stepAddr = a;
    endcase
  endfunction : stepAddr

  // Next read-register index whose mask bit is set, wrapping round
  function automatic logic [2:0] nextRead(input logic [2:0] cur, input logic [6:0] m);
    logic [2:0] k;
    nextRead = cur;
    k = cur;
    for (int i = 0; i < `NUM_RREGS; i++) begin
      k = (k == 3'h6) ? 3'h0 : k + 3'h1;
      if (m[k] && nextRead == cur) begin
        nextRead = k;
      end
    end
  endfunction : nextRead

  // ****************************************
  // State
  // ****************************************
  logic [7:0] wreg_ff [`NUM_WREGS];
  logic [7:0] nxt_wreg [`NUM_WREGS];
  logic [2:0] grp_ff, nxt_grp;
  logic [3:0] ptr_ff, nxt_ptr;
  logic [2:0] rdSeq_ff, nxt_rdSeq;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [1:0] rresp_ff, nxt_rresp;
  logic [7:0] rbyte_ff, nxt_rbyte;
  dma_regs_pkg::state_t state_ff, nxt_state;
  logic enabled_ff, nxt_enabled;
  logic forceRdy_ff, nxt_forceRdy;
  logic bus_request_line_ff, nxt_bus_request_line;
  logic [15:0] addrA_ff, nxt_addrA;
  logic [15:0] addrB_ff, nxt_addrB;
  logic [15:0] byteCnt_ff, nxt_byteCnt;
  logic matchPend_ff, nxt_matchPend;
  logic eobFlag_ff, nxt_eobFlag;
  logic matchFlag_ff, nxt_matchFlag;
  logic [15:0] sysAddr_ff, nxt_sysAddr;
  logic memRd_ff, nxt_memRd;
  logic memWr_ff, nxt_memWr;
  logic [7:0] wrData_ff, nxt_wrData;
  logic pulse_ff, nxt_pulse;

  // ****************************************
  // Decoded configuration
  // ****************************************
  logic wrTake, rdTake, cmdValid;
  logic [3:0] cmdCode;
  logic [7:0] wByte, statusByte, readByte;
  logic srcIsA, twoCyc, stopEob, stopMatch, autoRestart, pulseEn, rdyOk, matchHit;
  logic [1:0] opMode, xferCls, srcMode, dstMode;
  logic [15:0] blockLen, srcAddr;

  assign wByte = s_axi_wdata[7:0];
  assign wrTake = s_axi_awvalid & s_axi_wvalid & ~bvalid_ff;
  assign rdTake = s_axi_arvalid & ~rvalid_ff;
  assign srcIsA = wreg_ff[`IDX_G0_BASE][`F_CTRL];
  assign opMode = wreg_ff[`IDX_A_CFG][`F_MODE_LSB +: 2];
  assign xferCls = wreg_ff[`IDX_B_CFG][`F_MODE_LSB +: 2];
  assign twoCyc = wreg_ff[`IDX_B_TIMING][`F_TWO_CYC];
  assign stopMatch = wreg_ff[`IDX_G3_BASE][`F_CTRL];
  assign stopEob = wreg_ff[`IDX_G4_BASE][`F_CTRL];
  assign autoRestart = wreg_ff[`IDX_G5_BASE][`F_CTRL];
  assign pulseEn = wreg_ff[`IDX_PULSE_CTL][`F_PULSE_EN];
  assign srcMode = srcIsA ? wreg_ff[`IDX_A_CFG][1:0] : wreg_ff[`IDX_B_CFG][1:0];
  assign dstMode = srcIsA ? wreg_ff[`IDX_B_CFG][1:0] : wreg_ff[`IDX_A_CFG][1:0];
  assign blockLen = {wreg_ff[`IDX_LEN_HI], wreg_ff[`IDX_LEN_LO]};
  assign srcAddr = srcIsA ? addrA_ff : addrB_ff;
  assign rdyOk = readyIn | forceRdy_ff;
  // Mask bit set means "don't care" for that data bit
  assign matchHit = ((rdData ^ wreg_ff[`IDX_MATCH_VAL]) & ~wreg_ff[`IDX_MATCH_MASK]) == 8'h00;
  assign cmdValid = wrTake && s_axi_awaddr[7:0] == `WR_PORT_OFS && s_axi_wstrb[0] && ptr_ff == 4'h0
                    && wByte[2:0] == 3'h6;
  assign cmdCode = wByte[`F_CMD_LSB +: 4];
  assign statusByte = {2'h0, matchFlag_ff, eobFlag_ff, 2'h0, rdyOk, enabled_ff};

  always_comb begin : readMux
    case (rdSeq_ff)
      3'h0: readByte = statusByte;
      3'h1: readByte = byteCnt_ff[7:0];
      3'h2: readByte = byteCnt_ff[15:8];
      3'h3: readByte = addrA_ff[7:0];
      3'h4: readByte = addrA_ff[15:8];
      3'h5: readByte = addrB_ff[7:0];
      3'h6: readByte = addrB_ff[15:8];
      default: readByte = 8'h00;
    endcase
  end

  // ****************************************
  // Register bus and write groups
  // ****************************************
  always_comb begin : regNext
    nxt_wreg = wreg_ff;
    nxt_grp = grp_ff;
    nxt_ptr = ptr_ff;
    nxt_rdSeq = rdSeq_ff;
    nxt_bvalid = bvalid_ff & ~s_axi_bready;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff & ~s_axi_rready;
    nxt_rresp = rresp_ff;
    nxt_rbyte = rbyte_ff;
    if (wrTake) begin
      nxt_bvalid = 1'b1;
      nxt_bresp = `RESP_OKAY;
      if (s_axi_awaddr[7:0] != `WR_PORT_OFS) begin
        nxt_bresp = `RESP_SLVERR;
      end else if (s_axi_wstrb[0]) begin
        if (ptr_ff != 4'h0) begin
          // Pointed registers fill lowest pointer first
          nxt_wreg[grpStart(grp_ff) + 5'h01 + {3'h0, lowBit(ptr_ff)}] = wByte;
          nxt_ptr = ptr_ff & ~(4'h1 << lowBit(ptr_ff));
        end else if (wByte[2:0] != `GRP_NONE) begin
          nxt_wreg[grpStart(wByte[2:0])] = wByte;
          nxt_grp = wByte[2:0];
          nxt_ptr = wByte[`F_PTR_LSB +: 4] & ptrMask(wByte[2:0]);
        end
      end
    end
    if (cmdValid && cmdCode == `CMD_RD_RESTART) begin
      nxt_rdSeq = nextRead(3'h6, wreg_ff[`IDX_RD_MASK][6:0]);
    end
    if (rdTake) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = `RESP_OKAY;
      nxt_rbyte = 8'h00;
      case (s_axi_araddr[7:0])
        `RD_PORT_OFS: begin
          nxt_rbyte = readByte;
          nxt_rdSeq = nextRead(rdSeq_ff, wreg_ff[`IDX_RD_MASK][6:0]);
        end
        `STATUS_OFS: nxt_rbyte = statusByte;
        `WR_PORT_OFS: nxt_rbyte = 8'h00;
        default: nxt_rresp = `RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge clk) begin : regFlops
    if (rst) begin
      for (int i = 0; i < `NUM_WREGS; i++) begin
        wreg_ff[i] <= 8'h00;
      end
      wreg_ff[`IDX_RD_MASK] <= `RDMASK_RST;
      grp_ff <= 3'h0;
      ptr_ff <= 4'h0;
      rdSeq_ff <= 3'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `RESP_OKAY;
      rvalid_ff <= 1'b0;
      rresp_ff <= `RESP_OKAY;
      rbyte_ff <= 8'h00;
    end else begin
      wreg_ff <= nxt_wreg;
      grp_ff <= nxt_grp;
      ptr_ff <= nxt_ptr;
      rdSeq_ff <= nxt_rdSeq;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rbyte_ff <= nxt_rbyte;
    end
  end

  assign s_axi_awready = wrTake;
  assign s_axi_wready = wrTake;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = {24'h000000, rbyte_ff};

  // ****************************************
  // Transfer engine and counters
  // ****************************************
  logic stopNow, eobHit, matchStop, reload, isEob;

  always_comb begin : engineNext
    nxt_state = state_ff;
    nxt_enabled = enabled_ff;
    nxt_forceRdy = forceRdy_ff;
    nxt_bus_request_line = bus_request_line_ff;
    nxt_addrA = addrA_ff;
    nxt_addrB = addrB_ff;
    nxt_byteCnt = byteCnt_ff;
    nxt_matchPend = matchPend_ff;
    nxt_eobFlag = eobFlag_ff;
    nxt_matchFlag = matchFlag_ff;
    nxt_sysAddr = sysAddr_ff;
    nxt_wrData = wrData_ff;
    nxt_memRd = 1'b0;
    nxt_memWr = 1'b0;
    stopNow = 1'b0;
    eobHit = 1'b0;
    matchStop = 1'b0;
    reload = 1'b0;
    isEob = stopEob && byteCnt_ff == blockLen;
    case (state_ff)
      dma_regs_pkg::ST_IDLE: begin
        if (enabled_ff && rdyOk) begin
          nxt_bus_request_line = 1'b1;
          nxt_state = dma_regs_pkg::ST_REQ;
        end
      end
      dma_regs_pkg::ST_REQ: begin
        if (busGrantLine) begin
          nxt_state = dma_regs_pkg::ST_READ;
        end
      end
      dma_regs_pkg::ST_READ: begin
        if (srcIsA) begin
          nxt_addrA = stepAddr(addrA_ff, srcMode);
        end else begin
          nxt_addrB = stepAddr(addrB_ff, srcMode);
        end
        if (xferCls == `CLS_XFER || xferCls == `CLS_XSEARCH) begin
          nxt_wrData = rdData;
          nxt_matchPend = xferCls == `CLS_XSEARCH && matchHit;
          nxt_state = dma_regs_pkg::ST_WRITE;
        end else begin
          // Previous byte's match is only acted on now, one read later
          nxt_matchPend = matchHit;
          if (stopMatch && matchPend_ff) begin
            matchStop = 1'b1;
            stopNow = 1'b1;
            if (opMode != `OP_BYTE && rdyOk) begin
              nxt_byteCnt = byteCnt_ff + 16'h0001;
            end
          end else if (isEob) begin
            eobHit = 1'b1;
            stopNow = 1'b1;
            if (opMode != `OP_BYTE) begin
              nxt_byteCnt = byteCnt_ff + 16'h0001;
              if (xferCls == `CLS_SIM && twoCyc && readyIn) begin
                stopNow = 1'b0;
                nxt_state = dma_regs_pkg::ST_EXTRA;
              end
            end
          end else begin
            nxt_byteCnt = byteCnt_ff + 16'h0001;
            if (opMode == `OP_BYTE || (opMode == `OP_BURST && !rdyOk)) begin
              nxt_bus_request_line = 1'b0;
              nxt_state = dma_regs_pkg::ST_IDLE;
            end
          end
        end
      end
      dma_regs_pkg::ST_WRITE: begin
        if (stopMatch && matchPend_ff) begin
          matchStop = 1'b1;
          stopNow = 1'b1;
        end else if (isEob) begin
          eobHit = 1'b1;
          stopNow = 1'b1;
        end else begin
          nxt_byteCnt = byteCnt_ff + 16'h0001;
          if (srcIsA) begin
            nxt_addrB = stepAddr(addrB_ff, dstMode);
          end else begin
            nxt_addrA = stepAddr(addrA_ff, dstMode);
          end
          if (opMode == `OP_BYTE || (opMode == `OP_BURST && !rdyOk)) begin
            nxt_bus_request_line = 1'b0;
            nxt_state = dma_regs_pkg::ST_IDLE;
          end else begin
            nxt_state = dma_regs_pkg::ST_READ;
          end
        end
      end
      dma_regs_pkg::ST_EXTRA: begin
        if (srcIsA) begin
          nxt_addrA = stepAddr(addrA_ff, srcMode);
        end else begin
          nxt_addrB = stepAddr(addrB_ff, srcMode);
        end
        eobHit = 1'b1;
        stopNow = 1'b1;
      end
      default: nxt_state = dma_regs_pkg::ST_IDLE;
    endcase
    if (stopNow) begin
      nxt_bus_request_line = 1'b0;
      nxt_state = dma_regs_pkg::ST_IDLE;
      if (eobHit && autoRestart) begin
        reload = 1'b1;
      end else begin
        nxt_enabled = 1'b0;
      end
    end
    if (cmdValid) begin
      case (cmdCode)
        `CMD_LOAD: begin
          reload = 1'b1;
          nxt_eobFlag = 1'b0;
          nxt_matchFlag = 1'b0;
        end
        `CMD_ENABLE: begin
          reload = reload | ~enabled_ff;
          nxt_enabled = 1'b1;
        end
        `CMD_DISABLE: begin
          nxt_enabled = 1'b0;
          nxt_forceRdy = 1'b0;
          nxt_bus_request_line = 1'b0;
          nxt_state = dma_regs_pkg::ST_IDLE;
        end
        `CMD_FORCE_RDY: nxt_forceRdy = 1'b1;
        default: nxt_forceRdy = forceRdy_ff;
      endcase
    end
    // Buffer registers reach the counters only here, so mid-block writes wait for the next block
    if (reload) begin
      nxt_addrA = {wreg_ff[`IDX_A_HI], wreg_ff[`IDX_A_LO]};
      nxt_addrB = {wreg_ff[`IDX_B_HI], wreg_ff[`IDX_B_LO]};
      nxt_byteCnt = 16'h0000;
      nxt_matchPend = 1'b0;
    end
    // Flag set wins over a same-cycle clear
    if (stopNow && eobHit) begin
      nxt_eobFlag = 1'b1;
    end
    if (stopNow && matchStop) begin
      nxt_matchFlag = 1'b1;
    end
    if (nxt_state == dma_regs_pkg::ST_READ || nxt_state == dma_regs_pkg::ST_EXTRA) begin
      nxt_memRd = 1'b1;
      nxt_sysAddr = srcIsA ? nxt_addrA : nxt_addrB;
    end else if (nxt_state == dma_regs_pkg::ST_WRITE) begin
      nxt_memWr = 1'b1;
      nxt_sysAddr = srcIsA ? nxt_addrB : nxt_addrA;
    end
    nxt_pulse = bus_request_line_ff && busGrantLine && pulseEn && nxt_byteCnt != byteCnt_ff
                && nxt_byteCnt[7:0] == wreg_ff[`IDX_PULSE_OFS];
  end

  always_ff @(posedge clk) begin : engineFlops
    if (rst) begin
      state_ff <= dma_regs_pkg::ST_IDLE;
      enabled_ff <= 1'b0;
      forceRdy_ff <= 1'b0;
      bus_request_line_ff <= 1'b0;
      addrA_ff <= 16'h0000;
      addrB_ff <= 16'h0000;
      byteCnt_ff <= 16'h0000;
      matchPend_ff <= 1'b0;
      eobFlag_ff <= 1'b0;
      matchFlag_ff <= 1'b0;
      sysAddr_ff <= 16'h0000;
      memRd_ff <= 1'b0;
      memWr_ff <= 1'b0;
      wrData_ff <= 8'h00;
      pulse_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      enabled_ff <= nxt_enabled;
      forceRdy_ff <= nxt_forceRdy;
      bus_request_line_ff <= nxt_bus_request_line;
      addrA_ff <= nxt_addrA;
      addrB_ff <= nxt_addrB;
      byteCnt_ff <= nxt_byteCnt;
      matchPend_ff <= nxt_matchPend;
      eobFlag_ff <= nxt_eobFlag;
      matchFlag_ff <= nxt_matchFlag;
      sysAddr_ff <= nxt_sysAddr;
      memRd_ff <= nxt_memRd;
      memWr_ff <= nxt_memWr;
      wrData_ff <= nxt_wrData;
      pulse_ff <= nxt_pulse;
    end
  end

  assign busRequestLine = bus_request_line_ff;
  assign sysAddr = sysAddr_ff;
  assign memRd = memRd_ff;
  assign memWr = memWr_ff;
  assign wrData = wrData_ff;
  assign pulseOut = pulse_ff;

endmodule : dma_registers_and_counters

`default_nettype wire

// File: bench/dma_regs_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// ****************
// Port checks
// ****************
module dma_regs_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic busRequestLine,
  input wire logic busGrantLine,
  input wire logic memRd,
  input wire logic memWr,
  input wire logic [7:0] rdData,
  input wire logic [7:0] wrData,
  input wire logic pulseOut
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_wTake;
    s_axi_awvalid && s_axi_wvalid && s_axi_awready;
  endsequence
  sequence s_rTake;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_WR_ANSWER: assert property (
    s_wTake |=> s_axi_bvalid) else $error("write not answered");
  AST_B_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp not held");
  AST_RD_ANSWER: assert property (
    s_rTake |=> s_axi_rvalid) else $error("read not answered");
  AST_R_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata not held");
  AST_XFER_OWNED: assert property (
    memRd || memWr |-> busRequestLine && busGrantLine) else $error("transfer without bus");
  AST_WR_FOLLOWS_RD: assert property (
    memWr |-> $past(memRd) && wrData == $past(rdData)) else $error("write not from read");
  AST_PULSE_OWNED: assert property (
    pulseOut |-> $past(busRequestLine) && $past(busGrantLine)) else $error("pulse off bus");
  AST_PULSE_ONE: assert property (
    pulseOut |=> !pulseOut) else $error("pulse too long");
endmodule : dma_regs_checker
bind dma_registers_and_counters dma_regs_checker uChk (
  .clk, .rst, .s_axi_awvalid, .s_axi_wvalid, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .busRequestLine, .busGrantLine, .memRd, .memWr, .rdData, .wrData, .pulseOut
);
`default_nettype wire

// File: bench/mem_partner.sv
`timescale 1ns/10ps
`default_nettype none
// ****************
// Host grant and memory
// ****************
module mem_partner (
  input wire logic clk,
  input wire logic rst,
  input wire logic busRequestLine,
  input wire logic memRd,
  input wire logic memWr,
  input wire logic [15:0] sysAddr,
  input wire logic clrCnt,
  output logic busGrantLine,
  output logic [7:0] rdData,
  output var int nRd,
  output var int nWr
);
  logic [1:0] waitCnt = 2'h0;
  logic [7:0] lastRd = 8'h00;
  // Grant lags a random few cycles and falls the cycle after the request
  always @(posedge clk) begin
    if (rst || busRequestLine !== 1'b1) begin
      busGrantLine <= 1'b0;
      waitCnt <= 2'($urandom % 4);
    end else if (waitCnt == 2'h0) begin
      busGrantLine <= 1'b1;
    end else begin
      waitCnt <= waitCnt - 2'h1;
    end
    if (memRd === 1'b1) lastRd <= rdData;
    nRd <= clrCnt ? 0 : nRd + int'(memRd === 1'b1);
    nWr <= clrCnt ? 0 : nWr + int'(memWr === 1'b1);
  end
  // Outside a read the bus shows the inverse of the last byte, never a stale copy
  assign rdData = (memRd === 1'b1) ? sysAddr[7:0] ^ sysAddr[15:8] : ~lastRd;
endmodule : mem_partner
`default_nettype wire

// File: bench/dma_registers_and_counters_bench.sv
`timescale 1ns/10ps
`default_nettype none
// ****************
// Bench
// ****************
module dma_registers_and_counters_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awAddr = 8'h00;
  logic [7:0] arAddr = 8'h00;
  logic [31:0] wData = 32'h00000000;
  logic awValid = 1'b0;
  logic wValid = 1'b0;
  logic bReady = 1'b0;
  logic arValid = 1'b0;
  logic rReady = 1'b0;
  logic readyIn = 1'b0;
  logic clrCnt = 1'b1;
  logic awReady, wReady, bValid, arReady, rValid, busRequestLine, busGrantLine, memRd, memWr, pulseOut;
  logic [1:0] bResp, rResp;
  logic [31:0] rData;
  logic [15:0] sysAddr;
  logic [7:0] rdData, wrData;
  int nRd, nWr;
  int errTotal = 0;
  int nChecks = 0;
  int nPulse = 0;
  always #5 clk = ~clk;
  always @(posedge clk) nPulse <= clrCnt ? 0 : nPulse + int'(pulseOut === 1'b1);
  dma_registers_and_counters DUT (
    .clk(clk), .rst(rst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady), .busRequestLine(busRequestLine),
    .busGrantLine(busGrantLine), .readyIn(readyIn), .sysAddr(sysAddr), .memRd(memRd), .memWr(memWr),
    .rdData(rdData), .wrData(wrData), .pulseOut(pulseOut)
  );
  mem_partner uMem (
    .clk(clk), .rst(rst), .busRequestLine(busRequestLine), .memRd(memRd), .memWr(memWr),
    .sysAddr(sysAddr), .clrCnt(clrCnt), .busGrantLine(busGrantLine), .rdData(rdData), .nRd(nRd), .nWr(nWr)
  );
  task automatic final_report;
    $display("checks %0d mismatches %0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  task automatic chkv(input logic [15:0] got, input logic [15:0] exp);
    nChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask : chkv
  task automatic chkr(input logic [1:0] got, input logic [1:0] exp);
    nChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("[ERR] %0t response %h expected %h", $time, got, exp);
    end
  endtask : chkr
  // Waits on one handshake signal; a wait that runs out ends the run
  task automatic hs(input int w);
    int k;
    for (k = 0; k < 60; k++) begin
      @(posedge clk);
      if ((w == 0 ? awReady : w == 1 ? bValid : w == 2 ? arReady : rValid) === 1'b1) break;
    end
    if (k == 60) begin
      errTotal++;
      $display("[ERR] %0t wait ran out", $time);
      final_report();
    end
  endtask : hs
  task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk);
    awAddr <= a;
    wData <= {24'h000000, d};
    awValid <= 1'b1;
    wValid <= 1'b1;
    hs(0);
    awValid <= 1'b0;
    wValid <= 1'b0;
    @(posedge clk);
    bReady <= 1'b1;
    hs(1);
    bReady <= 1'b0;
    chkr(bResp, er);
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [1:0] er, output logic [7:0] d);
    @(posedge clk);
    arAddr <= a;
    arValid <= 1'b1;
    hs(2);
    arValid <= 1'b0;
    @(posedge clk);
    rReady <= 1'b1;
    hs(3);
    rReady <= 1'b0;
    d = rData[7:0];
    chkr(rResp, er);
  endtask : axr
  task automatic rs(output logic [15:0] v);
    logic [7:0] lo, hi;
    axr(8'h04, 2'h0, lo);
    axr(8'h04, 2'h0, hi);
    v = {hi, lo};
  endtask : rs
  function automatic logic [15:0] adv(input logic [15:0] a, input logic [1:0] m, input logic [15:0] n);
    return (m == 2'h0) ? a - n : (m == 2'h1) ? a + n : a;
  endfunction : adv
  initial begin : main
    logic [7:0] d, lo;
    logic [7:0] q[$];
    logic [15:0] as, bs, ln, v;
    logic [1:0] am, bm, op;
    int i, k;
    k = $urandom(13811);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    clrCnt <= 1'b0;
    axr(8'h08, 2'h0, d);
    chkv(16'(d), 16'h0000);
    axr(8'h04, 2'h0, d);
    chkv(16'(d), 16'h0000);
    axw(8'h0C, 8'h5A, 2'h2);
    axr(8'h0C, 2'h2, d);
    for (i = 0; i < 6; i++) begin
      as = 16'($urandom);
      bs = 16'($urandom);
      ln = (i == 0) ? 16'h0001 : 16'(1 + $urandom % 12);
      am = 2'(i % 3);
      bm = 2'($urandom % 3);
      op = 2'(i / 2);
      d = 8'($urandom % (32'(ln) + 2));
      q = {8'hF8, as[7:0], as[15:8], ln[7:0], ln[15:8], 8'h09, 8'({4'h0, op, am}), 8'h1A, 8'({6'h00, bm}), 8'h00,
           8'hFC, bs[7:0], bs[15:8], d, 8'h01, 8'h05, 8'h03, 8'h16};
      foreach (q[j]) wb(q[j]);
      axr(8'h08, 2'h0, lo);
      chkv(16'(lo & 8'h30), 16'h0000);
      clrCnt <= 1'b1;
      @(posedge clk);
      clrCnt <= 1'b0;
      if (i == 0) begin
        wb(8'h26);
        repeat (20) @(posedge clk);
        chkv(16'(busRequestLine), 16'h0000);
        readyIn <= 1'b1;
      end else begin
        readyIn <= 1'($urandom);
        wb(8'h46);
        wb(8'h26);
      end
      for (k = 0; k < 60; k++) begin
        axr(8'h08, 2'h0, lo);
        if (lo[4] === 1'b1) break;
      end
      chkv(16'(lo[4]), 16'h0001);
      chkv(16'(nRd), ln + 16'h0001);
      chkv(16'(nWr), ln + 16'h0001);
      if (op != 2'h0) chkv(16'(nPulse), 16'(d >= 8'h01 && 16'(d) <= ln));
      q = {8'h98, ~as[7:0], ~as[15:8], 8'h56};
      foreach (q[j]) wb(q[j]);
      axr(8'h04, 2'h0, lo);
      rs(v);
      chkv(v, ln);
      rs(v);
      chkv(v, adv(as, am, ln + 16'h0001));
      rs(v);
      chkv(v, adv(bs, bm, ln));
    end
    q = {8'h0E, 8'h0A, 8'h56};
    foreach (q[j]) wb(q[j]);
    rs(v);
    as = adv(as, am, ln + 16'h0001);
    chkv(v, {as[7:0], ln[7:0]});
    axr(8'h04, 2'h0, lo);
    chkv(16'(lo), {8'h00, ln[7:0]});
    axr(8'h08, 2'h0, lo);
    chkv(16'(lo & 8'h30), 16'h0010);
    // Burst search, stop on match; the matching byte is the third, at 16'h1202
    clrCnt <= 1'b1;
    @(posedge clk);
    clrCnt <= 1'b0;
    q = {8'hF8, 8'h00, 8'h12, 8'h10, 8'h00, 8'h09, 8'h05, 8'h1A, 8'h06, 8'h00, 8'h9B, 8'h00, 8'h10, 8'h16, 8'h46,
         8'h26};
    foreach (q[j]) wb(q[j]);
    for (k = 0; k < 60; k++) begin
      axr(8'h08, 2'h0, lo);
      if (lo[5] === 1'b1) break;
    end
    chkv(16'(lo & 8'h30), 16'h0020);
    // Match is seen one read late, so four reads and the count one past the match
    chkv(16'(nRd), 16'h0004);
    chkv(16'(nWr), 16'h0000);
    wb(8'h56);
    rs(v);
    chkv(v, 16'h0404);
    final_report();
  end : main
  task automatic wb(input logic [7:0] d);
    axw(8'h00, d, 2'h0);
  endtask : wb
endmodule : dma_registers_and_counters_bench
`default_nettype wire
